//--- src/usm_regs.vh
`ifndef USM_REGS_VH
`define USM_REGS_VH
// register indices on the 3-bit address port
`define USM_ADDR_DATA    3'h0
`define USM_ADDR_IEN     3'h1
`define USM_ADDR_IDENT   3'h2
`define USM_ADDR_LCTL    3'h3
`define USM_ADDR_HCTL    3'h4
`define USM_ADDR_LSTAT   3'h5
`define USM_ADDR_MSTAT   3'h6
// line status fields
`define USM_LS_READY     0
`define USM_LS_OVERRUN   1
`define USM_LS_PARITY    2
`define USM_LS_FRAMING   3
`define USM_LS_BREAK     4
`define USM_LS_THOLD     5
`define USM_LS_TSHIFT    6
// line control fields
`define USM_LC_PAR_EN    3
`define USM_LC_EVEN      4
`define USM_LC_DIV_ACC   7
// handshake control fields
`define USM_HC_LOOP      4
// identification codes, bits 2:0
`define USM_ID_NONE      3'h1
`define USM_ID_LINE      3'h6
`define USM_ID_RXDATA    3'h4
`define USM_ID_THOLD     3'h2
`define USM_ID_MODEM     3'h0
// reset values
`define USM_RST_LSTAT    8'h60
`define USM_RST_IEN      8'h00
`define USM_RST_HCTL     8'h00
`define USM_RST_LCTL     8'h00
`endif

//--- src/usm_sync2.v
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for pins
module usm_sync2 #(
   parameter W = 6
) (
   input  wire         clk_sys_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] d_i,
   output reg  [W-1:0] q_o
);
   reg [W-1:0] meta_reg;
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= {W{1'b1}};
         q_o      <= {W{1'b1}};
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule // usm_sync2
`default_nettype wire

//--- src/usm_irq_prio.v
`timescale 1ns/100ps
`default_nettype none
// combinational priority encoder for the identification code
module usm_irq_prio (
   input  wire       line_i,
   input  wire       rxdata_i,
   input  wire       thold_i,
   input  wire       modem_i,
   output reg  [2:0] code_o
);
`include "usm_regs.vh"
   always @* begin
      if (line_i) begin
         code_o = `USM_ID_LINE;
      end else if (rxdata_i) begin
         code_o = `USM_ID_RXDATA;
      end else if (thold_i) begin
         code_o = `USM_ID_THOLD;
      end else if (modem_i) begin
         code_o = `USM_ID_MODEM;
      end else begin
         code_o = `USM_ID_NONE;
      end
   end
endmodule // usm_irq_prio
`default_nettype wire

//--- src/usm_core.v
`timescale 1ns/100ps
`default_nettype none
//**********************************************************
// status, interrupt and handshake control
//**********************************************************
// Overview of operation
// - data ready sets on load, clears read/write0
// - overrun sets when unread char overwritten
// - parity error on wrong parity, clear on read
// - framing error when stop bit is zero
// - break when line low beyond character
// - overrun/parity/framing/break raise line interrupt
// - hold empty sets on transfer, clears on write
// - shift empty while shifter idle
// - line status bit 7 reads zero
// - priority line, rx data, tx empty, modem
// - identification frozen while being read
// - ident bit0 none, bits2:1 source code
// - enable bits gate four sources, upper zero
// - no enables, no interrupt, flags still update
// - control bits 0-3 drive outputs inverted outside loopback
// - loopback marks tx, loops serial and modem
// - loopback modem interrupts from control bits
// - software writes set status bits
// - handshake control bits 5-7 read zero
// - modem change flags, ring trailing edge only
// - modem status change and complement bits
// - even select one checks even parity
module usm_core (
   input  wire       clk_sys_i,
   input  wire       rst_n_i,
   input  wire [2:0] addr_i,
   input  wire [7:0] wdata_i,
   input  wire       wr_i,
   input  wire       rd_i,
   output reg  [7:0] rdata_o,
   input  wire       serial_rx_pin_i,
   output reg        serial_tx_pin_o,
   input  wire       cts_n_i,
   input  wire       dsr_n_i,
   input  wire       ri_n_i,
   input  wire       dcd_n_i,
   output reg        dtr_n_o,
   output reg        rts_n_o,
   output reg        out1_n_o,
   output reg        out2_n_o,
   output reg        irq_out_o,
   output reg        rx_line_o,
   input  wire       tx_shift_bit_i,
   input  wire       bit_tick_i,
   input  wire [3:0] char_bits_i,
   input  wire       rx_load_i,
   input  wire [7:0] rx_char_i,
   input  wire       rx_par_bit_i,
   input  wire       rx_stop_bit_i,
   input  wire       tx_xfer_i,
   input  wire       tx_idle_i,
   output reg        tx_hold_wr_o,
   output reg  [7:0] tx_hold_data_o,
   output reg        divisor_access_sel_o
);
`include "usm_regs.vh"
   //******************************************************
   // registers and state
   //******************************************************
   reg  [7:0] rx_buf_reg;
   reg        rx_char_ready_reg;
   reg        rx_overrun_reg;
   reg        rx_parity_flag_reg;
   reg        rx_framing_flag_reg;
   reg        rx_break_flag_reg;
   reg        tx_hold_empty_reg;
   reg        tx_shift_empty_reg;
   reg  [7:0] irq_enable_reg;
   reg  [7:0] handshake_ctl_reg;
   reg  [7:0] line_ctl_reg;
   reg  [3:0] mdm_change_reg;
   reg  [3:0] mdm_prev_reg;
   reg        thold_irq_reg;
   reg  [2:0] ident_frozen_reg;
   reg        ident_hold_reg;
   reg  [3:0] brk_cnt_reg;
   reg        brk_seen_reg;
   wire [4:0] pins_s;
   wire [2:0] ident_code;
   wire [2:0] ident_rep_w;
   wire       loop_w;
   wire       rx_in_w;
   wire [3:0] mdm_in_w;
   wire [3:0] mdm_edge_w;
   wire       rd_lstat_w;
   wire       rd_data_w;
   wire       rd_mstat_w;
   wire       rd_ident_w;
   wire       wr_data_w;
   wire       src_line_w;
   wire       src_rx_w;
   wire       src_th_w;
   wire       src_mdm_w;
   wire       par_bad_w;

   function [0:0] reg_hit;
      input [2:0] a;
      input [2:0] target;
      input       strobe;
      begin
         reg_hit = strobe && (a == target);
      end
   endfunction

   usm_sync2 #(.W(5)) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .d_i       ({serial_rx_pin_i, dcd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
      .q_o       (pins_s)
   );

   assign loop_w = handshake_ctl_reg[`USM_HC_LOOP];
   // loopback: tx shifter feeds rx, pins ignored
   assign rx_in_w = loop_w ? tx_shift_bit_i : pins_s[4];
   // active-high "on" view: cts, dsr, ri, dcd
   assign mdm_in_w = loop_w ? {handshake_ctl_reg[3], handshake_ctl_reg[2],
                               handshake_ctl_reg[0], handshake_ctl_reg[1]}
                            : ~pins_s[3:0];
   // ring flags only on on-to-off
   assign mdm_edge_w = {mdm_in_w[3] ^ mdm_prev_reg[3],
                        mdm_prev_reg[2] & ~mdm_in_w[2],
                        mdm_in_w[1:0] ^ mdm_prev_reg[1:0]};

   assign rd_lstat_w = reg_hit(addr_i, `USM_ADDR_LSTAT, rd_i);
   assign rd_mstat_w = reg_hit(addr_i, `USM_ADDR_MSTAT, rd_i);
   assign rd_ident_w = reg_hit(addr_i, `USM_ADDR_IDENT, rd_i);
   assign rd_data_w  = reg_hit(addr_i, `USM_ADDR_DATA, rd_i)
                       && !line_ctl_reg[`USM_LC_DIV_ACC];
   assign wr_data_w  = reg_hit(addr_i, `USM_ADDR_DATA, wr_i)
                       && !line_ctl_reg[`USM_LC_DIV_ACC];

   // even select 1 -> even count of ones incl. parity bit
   assign par_bad_w = line_ctl_reg[`USM_LC_PAR_EN] &&
                      ((^{rx_char_i, rx_par_bit_i}) == line_ctl_reg[`USM_LC_EVEN]);

   // enables gate each source
   assign src_line_w = irq_enable_reg[1] & (rx_overrun_reg | rx_parity_flag_reg
                       | rx_framing_flag_reg | rx_break_flag_reg);
   assign src_rx_w   = irq_enable_reg[0] & rx_char_ready_reg;
   assign src_th_w   = irq_enable_reg[2] & thold_irq_reg;
   assign src_mdm_w  = irq_enable_reg[3] & (|mdm_change_reg);

   usm_irq_prio u_prio (
      .line_i   (src_line_w),
      .rxdata_i (src_rx_w),
      .thold_i  (src_th_w),
      .modem_i  (src_mdm_w),
      .code_o   (ident_code)
   );
   assign ident_rep_w = ident_hold_reg ? ident_frozen_reg : ident_code;

   //******************************************************
   // status flags
   //******************************************************
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_buf_reg          <= 8'h00;
         rx_char_ready_reg   <= 1'b0;
         rx_overrun_reg      <= 1'b0;
         rx_parity_flag_reg  <= 1'b0;
         rx_framing_flag_reg <= 1'b0;
         rx_break_flag_reg   <= 1'b0;
         tx_hold_empty_reg   <= 1'b1;
         tx_shift_empty_reg  <= 1'b1;
         thold_irq_reg       <= 1'b1;
         mdm_change_reg      <= 4'h0;
         mdm_prev_reg        <= 4'h0;
         brk_cnt_reg         <= 4'h0;
         brk_seen_reg        <= 1'b0;
      end else begin
         mdm_prev_reg <= mdm_in_w;
         // clears first, then sets, so a coinciding event wins
         if (rd_data_w) begin
            rx_char_ready_reg <= 1'b0;
         end
         if (rd_lstat_w) begin
            rx_overrun_reg      <= 1'b0;
            rx_parity_flag_reg  <= 1'b0;
            rx_framing_flag_reg <= 1'b0;
            rx_break_flag_reg   <= 1'b0;
         end
         if (rd_mstat_w) begin
            mdm_change_reg <= 4'h0;
         end
         if (rd_ident_w && ident_rep_w == `USM_ID_THOLD) begin
            thold_irq_reg <= 1'b0;
         end
         if (reg_hit(addr_i, `USM_ADDR_LSTAT, wr_i)) begin
            // diagnostic: ones set, data ready also takes a zero
            rx_char_ready_reg   <= wdata_i[`USM_LS_READY];
            rx_overrun_reg      <= rx_overrun_reg | wdata_i[`USM_LS_OVERRUN];
            rx_parity_flag_reg  <= rx_parity_flag_reg | wdata_i[`USM_LS_PARITY];
            rx_framing_flag_reg <= rx_framing_flag_reg | wdata_i[`USM_LS_FRAMING];
            rx_break_flag_reg   <= rx_break_flag_reg | wdata_i[`USM_LS_BREAK];
            if (wdata_i[`USM_LS_THOLD]) begin
               tx_hold_empty_reg <= 1'b1;
               thold_irq_reg     <= 1'b1;
            end
         end
         if (reg_hit(addr_i, `USM_ADDR_MSTAT, wr_i)) begin
            mdm_change_reg <= mdm_change_reg | wdata_i[3:0];
         end
         if (wr_data_w) begin
            tx_hold_empty_reg <= 1'b0;
            thold_irq_reg     <= 1'b0;
         end
         if (tx_xfer_i) begin
            tx_hold_empty_reg  <= 1'b1;
            thold_irq_reg      <= 1'b1;
            tx_shift_empty_reg <= 1'b0;
         end else if (tx_idle_i) begin
            tx_shift_empty_reg <= 1'b1;
         end
         if (rx_load_i) begin
            rx_buf_reg        <= rx_char_i;
            rx_char_ready_reg <= 1'b1;
            if (rx_char_ready_reg && !rd_data_w) begin
               rx_overrun_reg <= 1'b1;
            end
            if (par_bad_w) begin
               rx_parity_flag_reg <= 1'b1;
            end
            if (!rx_stop_bit_i) begin
               rx_framing_flag_reg <= 1'b1;
            end
         end
         // break: spacing held beyond a whole character of bit ticks
         if (rx_in_w) begin
            brk_cnt_reg  <= 4'h0;
            brk_seen_reg <= 1'b0;
         end else if (bit_tick_i && !brk_seen_reg) begin
            if (brk_cnt_reg > char_bits_i) begin
               rx_break_flag_reg <= 1'b1;
               brk_seen_reg      <= 1'b1;
            end else begin
               brk_cnt_reg <= brk_cnt_reg + 4'h1;
            end
         end
         mdm_change_reg <= (rd_mstat_w ? 4'h0 : mdm_change_reg)
                           | mdm_edge_w
                           | (reg_hit(addr_i, `USM_ADDR_MSTAT, wr_i)
                              ? wdata_i[3:0] : 4'h0);
      end
   end

   //******************************************************
   // control registers and ident freeze
   //******************************************************
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_enable_reg    <= `USM_RST_IEN;
         handshake_ctl_reg <= `USM_RST_HCTL;
         line_ctl_reg      <= `USM_RST_LCTL;
         ident_frozen_reg  <= `USM_ID_NONE;
         ident_hold_reg    <= 1'b0;
      end else begin
         if (reg_hit(addr_i, `USM_ADDR_IEN, wr_i) && !line_ctl_reg[`USM_LC_DIV_ACC]) begin
            irq_enable_reg <= {4'h0, wdata_i[3:0]};
         end
         if (reg_hit(addr_i, `USM_ADDR_HCTL, wr_i)) begin
            // host must leave loopback only after reprogramming
            handshake_ctl_reg <= {3'h0, wdata_i[4:0]};
         end
         if (reg_hit(addr_i, `USM_ADDR_LCTL, wr_i)) begin
            line_ctl_reg <= wdata_i;
         end
         // freeze while the ident register is being read
         ident_hold_reg <= rd_ident_w;
         ident_frozen_reg <= rd_ident_w ? ident_rep_w : ident_code;
      end
   end

   //******************************************************
   // outputs and read data
   //******************************************************
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o              <= 8'h00;
         serial_tx_pin_o      <= 1'b1;
         dtr_n_o              <= 1'b1;
         rts_n_o              <= 1'b1;
         out1_n_o             <= 1'b1;
         out2_n_o             <= 1'b1;
         irq_out_o            <= 1'b0;
         rx_line_o            <= 1'b1;
         tx_hold_wr_o         <= 1'b0;
         tx_hold_data_o       <= 8'h00;
         divisor_access_sel_o <= 1'b0;
      end else begin
         serial_tx_pin_o <= loop_w ? 1'b1 : tx_shift_bit_i;
         rx_line_o       <= rx_in_w;
         // inverted drive; loopback leaves pins inactive
         dtr_n_o  <= loop_w | ~handshake_ctl_reg[0];
         rts_n_o  <= loop_w | ~handshake_ctl_reg[1];
         out1_n_o <= loop_w | ~handshake_ctl_reg[2];
         out2_n_o <= loop_w | ~handshake_ctl_reg[3];
         irq_out_o <= (ident_code != `USM_ID_NONE);
         tx_hold_wr_o   <= wr_data_w;
         tx_hold_data_o <= wr_data_w ? wdata_i : tx_hold_data_o;
         divisor_access_sel_o <= line_ctl_reg[`USM_LC_DIV_ACC];
         rdata_o <= 8'h00;
         if (rd_i) begin
            case (addr_i)
               `USM_ADDR_DATA:  rdata_o <= rx_buf_reg;
               `USM_ADDR_IEN:   rdata_o <= irq_enable_reg;
               `USM_ADDR_IDENT: rdata_o <= {5'h00, ident_rep_w};
               `USM_ADDR_LCTL:  rdata_o <= line_ctl_reg;
               `USM_ADDR_HCTL:  rdata_o <= handshake_ctl_reg;
               `USM_ADDR_LSTAT: rdata_o <= {1'b0, tx_shift_empty_reg, tx_hold_empty_reg,
                                            rx_break_flag_reg, rx_framing_flag_reg,
                                            rx_parity_flag_reg, rx_overrun_reg,
                                            rx_char_ready_reg};
               `USM_ADDR_MSTAT: rdata_o <= {mdm_in_w, mdm_change_reg};
               default:         rdata_o <= 8'h00;
            endcase
         end
      end
   end
endmodule // usm_core
`default_nettype wire

//--- verification/usm_core_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "usm_regs.vh"
module usm_core_monitor (
   input wire logic       clk_sys_i,
   input wire logic       rst_n_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic       serial_tx_pin_o,
   input wire logic       dtr_n_o,
   input wire logic       rts_n_o,
   input wire logic       out1_n_o,
   input wire logic       out2_n_o,
   input wire logic       irq_out_o,
   input wire logic       rx_line_o,
   input wire logic       tx_shift_bit_i,
   input wire logic       tx_hold_wr_o,
   input wire logic [7:0] tx_hold_data_o,
   input wire logic       divisor_access_sel_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   //**********************************************************
   // shadow of host writes
   //**********************************************************
   logic [7:0] hc_reg;
   logic [3:0] ien_reg;
   wire  [3:0] pins = {out2_n_o, out1_n_o, rts_n_o, dtr_n_o};
   wire        loop = hc_reg[`USM_HC_LOOP];
   wire        en_ok = !divisor_access_sel_o;
   wire        dat_wr = wr_i && addr_i == `USM_ADDR_DATA && en_ok;
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hc_reg  <= 8'h00;
         ien_reg <= 4'h0;
      end else begin
         if (wr_i && addr_i == `USM_ADDR_HCTL)
            hc_reg <= wdata_i;
         // enable writes are dropped while divisor access is set
         if (wr_i && addr_i == `USM_ADDR_IEN && en_ok)
            ien_reg <= wdata_i[3:0];
      end
   end
   //**********************************************************
   // checks
   //**********************************************************
   property p_ls_top;
      rd_i && addr_i == `USM_ADDR_LSTAT |=> !rdata_o[7];
   endproperty
   a_ls_top: assert property (p_ls_top)
      else $error("line status top bit set");
   property p_id_fmt;
      rd_i && addr_i == `USM_ADDR_IDENT
         |=> rdata_o[7:3] == 5'h00 && rdata_o[2:0] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
   endproperty
   a_id_fmt: assert property (p_id_fmt)
      else $error("bad identification code");
   property p_id_off;
      rd_i && addr_i == `USM_ADDR_IDENT && ien_reg == 4'h0 |=> rdata_o == 8'h01;
   endproperty
   a_id_off: assert property (p_id_off)
      else $error("identification not idle with enables off");
   property p_irq_off;
      ien_reg == 4'h0 && $past(ien_reg) == 4'h0 |-> !irq_out_o;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("interrupt with enables off");
   property p_ien_hi;
      rd_i && addr_i == `USM_ADDR_IEN && en_ok |=> rdata_o[7:4] == 4'h0;
   endproperty
   a_ien_hi: assert property (p_ien_hi)
      else $error("enable upper bits set");
   property p_hc_hi;
      rd_i && addr_i == `USM_ADDR_HCTL |=> rdata_o[7:5] == 3'h0;
   endproperty
   a_hc_hi: assert property (p_hc_hi)
      else $error("handshake upper bits set");
   property p_pins;
      !loop && $stable(hc_reg) |-> pins == ~hc_reg[3:0];
   endproperty
   a_pins: assert property (p_pins)
      else $error("handshake outputs not inverted");
   property p_loop_pins;
      loop && $past(loop) |-> serial_tx_pin_o && pins == 4'hf;
   endproperty
   a_loop_pins: assert property (p_loop_pins)
      else $error("pins not parked in loopback");
   property p_loop_rx;
      loop && $past(loop) |-> rx_line_o == $past(tx_shift_bit_i);
   endproperty
   a_loop_rx: assert property (p_loop_rx)
      else $error("receiver not fed from shifter");
   property p_tx_norm;
      !loop && !$past(loop) && $past(rst_n_i) |-> serial_tx_pin_o == $past(tx_shift_bit_i);
   endproperty
   a_tx_norm: assert property (p_tx_norm)
      else $error("serial output not from shifter");
   property p_hold;
      dat_wr |=> tx_hold_wr_o && tx_hold_data_o == $past(wdata_i);
   endproperty
   a_hold: assert property (p_hold)
      else $error("holding write not passed on");
endmodule // usm_core_monitor
`default_nettype wire

//--- verification/usm_modem_model.sv
`timescale 1ns/100ps
`default_nettype none
module usm_modem_model (
   input  wire logic       clk_sys_i,
   input  wire logic       slow_i,
   input  wire logic [3:0] on_i,
   input  wire logic       break_i,
   output wire logic       cts_n_o,
   output wire logic       dsr_n_o,
   output wire logic       ri_n_o,
   output wire logic       dcd_n_o,
   output wire logic       serial_o
);
   // on_i order cts, dsr, ri, dcd; slow answers three cycles later
   logic [3:0][4:0] pipe_reg = '0;
   wire  [4:0]      now = slow_i ? pipe_reg[3] : pipe_reg[0];
   always @(posedge clk_sys_i)
      pipe_reg <= {pipe_reg[2:0], break_i, on_i};
   // line idles at marking unless break is held
   assign {serial_o, dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} = ~now;
endmodule // usm_modem_model
`default_nettype wire

//--- verification/tb_usm_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "usm_regs.vh"
module tb_usm_core;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [2:0]  addr_i = 3'h0;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        tx_shift_bit_i = 1'b1;
   logic        bit_tick_i = 1'b0;
   logic        rx_load_i = 1'b0;
   logic [7:0]  rx_char_i = 8'h00;
   logic        rx_par_bit_i = 1'b0;
   logic        rx_stop_bit_i = 1'b1;
   logic        tx_xfer_i = 1'b0;
   logic        tx_idle_i = 1'b1;
   logic        slow = 1'b0;
   logic        brk = 1'b0;
   logic [3:0]  lines = 4'h0;
   logic [15:0] cyc = 16'h0000;
   int          fails = 0;
   int          check_count = 0;
   logic [7:0]  c;
   logic        p, s, ev;
   wire  [7:0]  rdata_o, tx_hold_data_o;
   wire         ser_rx, cts_n, dsr_n, ri_n, dcd_n, serial_tx_pin_o, irq_out_o, rx_line_o;
   wire         dtr_n_o, rts_n_o, out1_n_o, out2_n_o, tx_hold_wr_o, divisor_access_sel_o;
   wire  [7:0]  pins = {4'h0, out2_n_o, out1_n_o, rts_n_o, dtr_n_o};
   logic [7:0]  lp_on [4] = '{8'h22, 8'h11, 8'h40, 8'h88};
   logic [7:0]  lp_off [4] = '{8'h02, 8'h01, 8'h04, 8'h08};
   usm_core dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .serial_rx_pin_i(ser_rx), .serial_tx_pin_o(serial_tx_pin_o), .cts_n_i(cts_n),
      .dsr_n_i(dsr_n), .ri_n_i(ri_n), .dcd_n_i(dcd_n), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o),
      .out1_n_o(out1_n_o), .out2_n_o(out2_n_o), .irq_out_o(irq_out_o), .rx_line_o(rx_line_o),
      .tx_shift_bit_i(tx_shift_bit_i), .bit_tick_i(bit_tick_i), .char_bits_i(4'ha),
      .rx_load_i(rx_load_i), .rx_char_i(rx_char_i), .rx_par_bit_i(rx_par_bit_i),
      .rx_stop_bit_i(rx_stop_bit_i), .tx_xfer_i(tx_xfer_i), .tx_idle_i(tx_idle_i),
      .tx_hold_wr_o(tx_hold_wr_o), .tx_hold_data_o(tx_hold_data_o),
      .divisor_access_sel_o(divisor_access_sel_o));
   usm_modem_model modem_u (.clk_sys_i(clk_sys_i), .slow_i(slow), .on_i(lines),
      .break_i(brk), .cts_n_o(cts_n), .dsr_n_o(dsr_n), .ri_n_o(ri_n), .dcd_n_o(dcd_n),
      .serial_o(ser_rx));
   //**********************************************************
   // host tasks
   //**********************************************************
   task automatic print_verdict;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("FAIL %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   // read data stand one cycle only: check mid-cycle, return on an edge
   task automatic rchk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(negedge clk_sys_i) chk(rdata_o & m, e & m);
      @(posedge clk_sys_i);
   endtask
   task automatic load(input logic [7:0] d, input logic pb, input logic sb);
      @(posedge clk_sys_i);
      rx_char_i <= d;
      rx_par_bit_i <= pb;
      rx_stop_bit_i <= sb;
      rx_load_i <= 1'b1;
      @(posedge clk_sys_i);
      rx_load_i <= 1'b0;
   endtask
   function automatic logic [7:0] ls_exp(input logic [7:0] d, input logic pb, sb, e);
      return {3'h3, 1'b0, ~sb, (^{d, pb}) == e, 2'h1};
   endfunction
   initial forever #2 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 16'h0001;
      bit_tick_i <= cyc[1:0] == 2'h3;
      tx_shift_bit_i <= 1'($urandom);
      if (cyc == 16'h4e20) begin
         fails++;
         print_verdict;
      end
   end
   //**********************************************************
   // main sequence
   //**********************************************************
   initial begin
      void'($urandom(32'h54ce));
      repeat (10) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rchk(`USM_ADDR_LSTAT, `USM_RST_LSTAT, 8'hff);
      rchk(`USM_ADDR_IDENT, 8'h01, 8'hff);
      chk(pins, 8'h0f);
      for (int i = 0; i < 12; i++) begin
         c = 8'($urandom);
         p = 1'($urandom);
         s = 1'($urandom);
         ev = 1'($urandom);
         wr(`USM_ADDR_LCTL, {3'h0, ev, 4'hb});
         load(c, p, s);
         rchk(`USM_ADDR_LSTAT, ls_exp(c, p, s, ev), 8'hff);
         rchk(`USM_ADDR_DATA, c, 8'hff);
      end
      load(8'h3c, 1'b0, 1'b1);
      load(8'hc3, 1'b0, 1'b1);
      rchk(`USM_ADDR_LSTAT, 8'h03, 8'h03);
      rchk(`USM_ADDR_LSTAT, 8'h01, 8'h03);
      rchk(`USM_ADDR_DATA, 8'hc3, 8'hff);
      load(8'h3c, 1'b0, 1'b1);
      wr(`USM_ADDR_LSTAT, 8'h00);
      rchk(`USM_ADDR_LSTAT, 8'h00, 8'h01);
      brk <= 1'b1;
      idle(32);
      rchk(`USM_ADDR_LSTAT, 8'h00, 8'h10);
      idle(32);
      rchk(`USM_ADDR_LSTAT, 8'h10, 8'h10);
      brk <= 1'b0;
      idle(12);
      rchk(`USM_ADDR_LSTAT, 8'h60, 8'hff);
      rchk(`USM_ADDR_MSTAT, 8'h00, 8'hf0);
      lines <= 4'h1;
      idle(12);
      wr(`USM_ADDR_IEN, 8'h0f);
      rchk(`USM_ADDR_IEN, 8'h0f, 8'hff);
      wr(`USM_ADDR_DATA, 8'ha5);
      rchk(`USM_ADDR_LSTAT, 8'h00, 8'h20);
      @(posedge clk_sys_i);
      tx_xfer_i <= 1'b1;
      tx_idle_i <= 1'b0;
      @(posedge clk_sys_i);
      tx_xfer_i <= 1'b0;
      wr(`USM_ADDR_LCTL, 8'h1b);
      load(8'h01, 1'b0, 1'b1);
      idle(2);
      chk({7'h00, irq_out_o}, 8'h01);
      rchk(`USM_ADDR_IDENT, 8'h06, 8'hff);
      rchk(`USM_ADDR_LSTAT, 8'h25, 8'hff);
      rchk(`USM_ADDR_IDENT, 8'h04, 8'hff);
      rchk(`USM_ADDR_DATA, 8'h01, 8'hff);
      rchk(`USM_ADDR_IDENT, 8'h02, 8'hff);
      rchk(`USM_ADDR_IDENT, 8'h00, 8'hff);
      rchk(`USM_ADDR_MSTAT, 8'h11, 8'hff);
      rchk(`USM_ADDR_IDENT, 8'h01, 8'hff);
      tx_idle_i <= 1'b1;
      chk({7'h00, irq_out_o}, 8'h00);
      rchk(`USM_ADDR_LSTAT, 8'h40, 8'h40);
      slow <= 1'b1;
      lines <= 4'h5;
      idle(12);
      rchk(`USM_ADDR_MSTAT, 8'h50, 8'hff);
      lines <= 4'h1;
      idle(12);
      rchk(`USM_ADDR_MSTAT, 8'h14, 8'hff);
      lines <= 4'ha;
      idle(12);
      rchk(`USM_ADDR_MSTAT, 8'hab, 8'hff);
      wr(`USM_ADDR_IEN, 8'h00);
      load(8'h01, 1'b0, 1'b1);
      idle(2);
      chk({7'h00, irq_out_o}, 8'h00);
      rchk(`USM_ADDR_LSTAT, 8'h05, 8'h05);
      rchk(`USM_ADDR_DATA, 8'h01, 8'hff);
      wr(`USM_ADDR_LCTL, 8'h83);
      wr(`USM_ADDR_IEN, 8'h0f);
      chk({7'h00, divisor_access_sel_o}, 8'h01);
      wr(`USM_ADDR_LCTL, 8'h03);
      rchk(`USM_ADDR_IEN, 8'h00, 8'hff);
      rchk(`USM_ADDR_MSTAT, 8'ha0, 8'hf0);
      for (int i = 0; i < 4; i++) begin
         c = 8'($urandom) & 8'hef;
         wr(`USM_ADDR_HCTL, c);
         idle(2);
         chk(pins, {4'h0, ~c[3:0]});
         rchk(`USM_ADDR_HCTL, c & 8'h1f, 8'hff);
      end
      wr(`USM_ADDR_HCTL, 8'h10);
      idle(3);
      chk(pins, 8'h0f);
      rchk(`USM_ADDR_MSTAT, 8'h00, 8'hf0);
      wr(`USM_ADDR_IEN, 8'h08);
      for (int k = 0; k < 4; k++) begin
         wr(`USM_ADDR_HCTL, 8'h10 | (8'h01 << k));
         idle(4);
         rchk(`USM_ADDR_IDENT, (k == 2) ? 8'h01 : 8'h00, 8'hff);
         rchk(`USM_ADDR_MSTAT, lp_on[k], 8'hff);
         wr(`USM_ADDR_HCTL, 8'h10);
         idle(4);
         rchk(`USM_ADDR_MSTAT, lp_off[k], 8'hff);
      end
      wr(`USM_ADDR_IEN, 8'h02);
      wr(`USM_ADDR_LSTAT, 8'h1e);
      rchk(`USM_ADDR_IDENT, 8'h06, 8'hff);
      rchk(`USM_ADDR_LSTAT, 8'h1e, 8'h1f);
      rchk(`USM_ADDR_IDENT, 8'h01, 8'hff);
      wr(`USM_ADDR_IEN, 8'h08);
      wr(`USM_ADDR_MSTAT, 8'h0f);
      rchk(`USM_ADDR_IDENT, 8'h00, 8'hff);
      rchk(`USM_ADDR_MSTAT, 8'h0f, 8'hff);
      wr(`USM_ADDR_IEN, 8'h00);
      wr(`USM_ADDR_HCTL, 8'h00);
      idle(3);
      chk(pins, 8'h0f);
      print_verdict;
   end
endmodule // tb_usm_core
bind usm_core usm_core_monitor mon_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .serial_tx_pin_o(serial_tx_pin_o), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o),
   .out1_n_o(out1_n_o), .out2_n_o(out2_n_o), .irq_out_o(irq_out_o), .rx_line_o(rx_line_o),
   .tx_shift_bit_i(tx_shift_bit_i), .tx_hold_wr_o(tx_hold_wr_o),
   .tx_hold_data_o(tx_hold_data_o), .divisor_access_sel_o(divisor_access_sel_o));
`default_nettype wire
